/* rtl/pmpio_top.sv */
// Handshake, switching and indication logic toward the controller
`timescale 1ns/1ps
module pmpio_top import pmpio_pkg::*; #(
   parameter int FLASH_CYCLES = FLASH_CYC
) (
   input  wire  logic                   core_clk,
   input  wire  logic                   resetn,
   // Controller pins, asynchronous
   input  wire  logic                   meas_req_in,
   input  wire  logic                   reject_confirm_in,
   input  wire  logic                   stats_clear_in,
   input  wire  logic                   sensor_check_in,
   // Configuration
   input  wire  logic                   online_eval_en,
   input  wire  logic                   ack_reject_en,
   input  wire  logic                   test_mode,
   input  wire  logic [N_SW*2-1:0]      sw_channel,
   input  wire  logic [N_SW*2-1:0]      sw_ref,
   input  wire  logic [N_SW*DW-1:0]     sw_setval,
   input  wire  logic [DW-1:0]          x_zero,
   input  wire  logic [DW-1:0]          x_ref,
   input  wire  logic [DW-1:0]          y_ref,
   input  wire  logic [DW-1:0]          tolerance,
   input  wire  logic [3:0]             prog_sel,
   // Measurement core side
   input  wire  logic [DW-1:0]          x_val,
   input  wire  logic [DW-1:0]          y_val,
   input  wire  logic                   trigger_evt,
   input  wire  logic                   win_bad_exit,
   input  wire  logic                   eval_done,
   input  wire  logic                   eval_reject,
   // Outputs
   output logic                         ready_out,
   output logic                         meas_active_out,
   output logic                         online_reject_flag,
   output logic [N_SW-1:0]              threshold_switch_out,
   output logic                         fail_result_out,
   output logic                         reject_lamp_out,
   output logic                         interlock_out,
   output logic                         buzzer_out,
   output logic                         sensor_check_pass_out,
   output logic [CW-1:0]                part_count_out,
   output logic [CW-1:0]                reject_count_out,
   output logic [7:0]                   reject_pct_out
);

   typedef struct packed {
      logic [1:0]              s_meas;
      logic [1:0]              s_conf;
      logic [1:0]              s_clr;
      logic [1:0]              s_chk;
      pmpio_st_t               st;
      logic [DW-1:0]           trig_x;
      logic                    trig_seen;
      logic                    ready;
      logic                    onl;
      logic [N_SW-1:0]         sw;
      logic                    fail;
      logic                    lamp;
      logic                    lamp_steady;
      logic                    lock;
      logic                    buzz_on;
      logic                    buzz;
      logic [7:0]              pwm_cnt;
      logic [31:0]             flash_cnt;
      logic                    flash;
      logic                    pass;
      logic [4:0]              clr_idx;
      logic [N_PROG*CW-1:0]    parts;
      logic [N_PROG*CW-1:0]    rejects;
      // Output copies, so every pin leaves a flip-flop
      logic                    meas_act;
      logic                    lamp_o;
      logic [7:0]              pct;
      logic [CW-1:0]           part_o;
      logic [CW-1:0]           rej_o;
   } pmpio_state_t;

   pmpio_state_t q, d;

   // Absolute difference, used for both sensor channels
   function automatic logic in_tol(input logic [DW-1:0] a, input logic [DW-1:0] b,
                                   input logic [DW-1:0] t);
      logic [DW-1:0] diff;
      diff = (a > b) ? a - b : b - a;
      return diff <= t;
   endfunction

   // Reject percentage of the selected program
   logic [CW-1:0] sel_parts;
   logic [CW-1:0] sel_rej;
   logic [CW+6:0] pct_full;
   always_comb begin
      sel_parts = q.parts[prog_sel*CW +: CW];
      sel_rej   = q.rejects[prog_sel*CW +: CW];
      pct_full  = (sel_parts == '0) ? '0 : (CW+7)'((({7'h00, sel_rej}) * 7'h64) / {7'h00, sel_parts});
   end

   // Threshold compare, one per switch
   logic [N_SW-1:0] sw_hit;
   logic [N_SW-1:0] sw_upd;
   logic [DW-1:0]   x_rel;
   // Position since the trigger; wraps behind it, so the compare guards that case
   assign x_rel = x_val - q.trig_x;
   genvar g;
   generate
      for (g = 0; g < N_SW; g++) begin : g_sw
         logic [1:0]    ch;
         logic [1:0]    rf;
         logic [DW-1:0] sv;
         logic          hit;
         logic          upd;
         assign ch = sw_channel[g*2 +: 2];
         assign rf = sw_ref[g*2 +: 2];
         assign sv = sw_setval[g*DW +: DW];
         // One process per switch; the shared vectors are fed by plain assigns
         always_comb begin
            if (ch == CH_Y) begin
               // R10 Y channel compare
               hit = y_val > sv;
               upd = 1'b1;
            end else if (rf == REF_TRIG) begin
               // R9 trigger relative X, no hit behind the trigger point
               hit = (x_val > q.trig_x) && (x_rel > sv);
               upd = (q.st == PM_MEAS) && q.trig_seen;
            end else begin
               // R7 zero point reference, no hit below the zero point
               hit = (x_val > x_zero) && ((x_val - x_zero) > sv);
               upd = 1'b1;
            end
         end
         assign sw_hit[g] = hit;
         assign sw_upd[g] = upd;
         // Switch follows its compare while updating
         a_sw_follow: assert property (@(posedge core_clk) disable iff (!resetn) // R6 R10
            sw_upd[g] |=> (threshold_switch_out[g] == $past(sw_hit[g])))
            else $error("switch did not follow compare");
         // Trigger switch frozen outside its window
         a_sw_hold: assert property (@(posedge core_clk) disable iff (!resetn) // R9
            !sw_upd[g] |=> $stable(threshold_switch_out[g]))
            else $error("switch changed while frozen");
      end
   endgenerate

   // Next state
   always_comb begin
      logic meas;
      logic conf;
      logic clr;
      logic chk;
      meas = q.s_meas[1];
      conf = q.s_conf[1];
      clr  = q.s_clr[1];
      chk  = q.s_chk[1];
      d = q;
      d.s_meas = {q.s_meas[0], meas_req_in};
      d.s_conf = {q.s_conf[0], reject_confirm_in};
      d.s_clr  = {q.s_clr[0], stats_clear_in};
      d.s_chk  = {q.s_chk[0], sensor_check_in};
      // R5 R6 R8 switches refresh in measurement and test operation
      for (int i = 0; i < N_SW; i++) begin
         if (sw_upd[i])
            d.sw[i] = sw_hit[i];
      end
      // Lamp flash and buzzer PWM timebases
      if (q.flash_cnt >= 32'(FLASH_CYCLES - 1)) begin
         d.flash_cnt = '0;
         d.flash     = ~q.flash;
      end else begin
         d.flash_cnt = q.flash_cnt + 32'h1;
      end
      d.pwm_cnt = (q.pwm_cnt >= PWM_PERIOD) ? 8'h00 : q.pwm_cnt + 8'h01;
      case (q.st)
         PM_IDLE: begin
            // R3 start taken only from standby
            if (meas) begin
               d.st = PM_MEAS;
               d.ready = 1'b0;
               // R2 new measurement clears flag
               d.onl = 1'b0;
               // R13 R14 indications end at next start
               d.lamp = 1'b0;
               d.lamp_steady = 1'b0;
               d.buzz_on = 1'b0;
               d.lock = 1'b0;
               d.fail = 1'b1;
               d.trig_seen = 1'b0;
            end else if (clr) begin
               // R17 ready low during clear
               d.st = PM_CLR;
               d.ready = 1'b0;
               d.clr_idx = '0;
            end else if (chk) begin
               // R20 ready low during check
               d.st = PM_STEST;
               d.ready = 1'b0;
            end
         end
         PM_MEAS: begin
            if (trigger_evt && !q.trig_seen) begin
               d.trig_seen = 1'b1;
               d.trig_x = x_val;
            end
            // R1 R4 only forbidden exits set the flag
            if (online_eval_en && win_bad_exit)
               d.onl = 1'b1;
            // R22 request low ends measurement
            if (!meas)
               d.st = PM_EVAL;
         end
         PM_EVAL: begin
            if (eval_done) begin
               d.fail = eval_reject;
               d.parts[prog_sel*CW +: CW] = sel_parts + CW'(1);
               if (eval_reject) begin
                  d.rejects[prog_sel*CW +: CW] = sel_rej + CW'(1);
                  d.lamp = 1'b1;
                  d.buzz_on = 1'b1;
               end
               if (eval_reject && ack_reject_en) begin
                  // R11 hold for acknowledgement
                  d.lock = 1'b1;
                  d.st = PM_ACK;
               end else begin
                  d.st = PM_IDLE;
                  d.ready = 1'b1;
               end
            end
         end
         PM_ACK: begin
            // R12 confirm steadies lamp, drops lock and buzzer
            if (conf) begin
               d.lamp_steady = 1'b1;
               d.lock = 1'b0;
               d.buzz_on = 1'b0;
               // R13 ready back at cycle end
               d.st = PM_IDLE;
               d.ready = 1'b1;
            end
         end
         PM_CLR: begin
            // R15 one program zeroed per cycle
            d.parts[q.clr_idx[3:0]*CW +: CW] = '0;
            d.rejects[q.clr_idx[3:0]*CW +: CW] = '0;
            d.clr_idx = q.clr_idx + 5'h01;
            if (q.clr_idx == 5'(N_PROG - 1))
               d.st = PM_WAIT;
         end
         PM_STEST: begin
            // R18 R19 compare both channels
            d.pass = in_tol(x_val, x_ref, tolerance) && in_tol(y_val, y_ref, tolerance);
            d.st = PM_WAIT;
         end
         PM_WAIT: begin
            // R16 R21 wait for request withdrawal
            if (!clr && !chk) begin
               d.st = PM_IDLE;
               d.ready = 1'b1;
            end
         end
         default: d.st = PM_IDLE;
      endcase
      // R11 flashing lamp and PWM buzzer
      d.buzz = d.buzz_on && (q.pwm_cnt < PWM_HIGH);
      if (!test_mode && q.st == PM_IDLE && !q.ready)
         d.ready = 1'b1;
      // Output copies taken from the next state, no extra lag, except the percentage
      d.meas_act = (d.st == PM_MEAS);
      d.part_o   = d.parts[prog_sel*CW +: CW];
      d.rej_o    = d.rejects[prog_sel*CW +: CW];
      // Percentage trails the counters by one cycle; the divider stays off the counter path
      d.pct      = pct_full[7:0];
      // R11 R12 flashing until confirm, steady after it
      d.lamp_o   = d.lamp && (d.lamp_steady || d.flash || !ack_reject_en);
   end

   // State register, synchronous reset
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         q <= '0;
         q.st <= PM_IDLE;
         q.ready <= 1'b1;
      end else begin
         q <= d;
      end
   end

   // Outputs straight from the state register
   assign ready_out             = q.ready;
   assign meas_active_out       = q.meas_act;
   assign online_reject_flag    = q.onl;
   assign threshold_switch_out  = q.sw;
   assign fail_result_out       = q.fail;
   assign reject_lamp_out       = q.lamp_o;
   assign interlock_out         = q.lock;
   assign buzzer_out            = q.buzz;
   assign sensor_check_pass_out = q.pass;
   assign part_count_out        = q.part_o;
   assign reject_count_out      = q.rej_o;
   assign reject_pct_out        = q.pct;

   // Assertions
   a_onl_clear_start: assert property (@(posedge core_clk) disable iff (!resetn) // R2
      $rose(meas_active_out) |-> !online_reject_flag) else $error("online flag not cleared at start");
   a_onl_set_viol: assert property (@(posedge core_clk) disable iff (!resetn) // R1
      (q.st == PM_MEAS && online_eval_en && win_bad_exit) |=> online_reject_flag)
      else $error("violation did not set online flag");
   a_onl_no_cause: assert property (@(posedge core_clk) disable iff (!resetn) // R4
      (!online_eval_en && !online_reject_flag && !$rose(meas_active_out)) |=> !online_reject_flag)
      else $error("online flag set without cause");
   a_ack_clears: assert property (@(posedge core_clk) disable iff (!resetn) // R12
      (q.st == PM_ACK && q.s_conf[1]) |=> (!interlock_out && !buzzer_out && q.lamp_steady))
      else $error("confirm did not clear lock and buzzer");
   a_ack_lock: assert property (@(posedge core_clk) disable iff (!resetn) // R11
      (q.st == PM_EVAL && eval_done && eval_reject && ack_reject_en) |=> (interlock_out && fail_result_out))
      else $error("reject did not raise lock");
   a_ack_ready: assert property (@(posedge core_clk) disable iff (!resetn) // R13
      (q.st == PM_ACK && q.s_conf[1]) |=> ready_out) else $error("ready not back after confirm");
   a_clr_ready: assert property (@(posedge core_clk) disable iff (!resetn) // R17
      (q.st == PM_CLR) |-> !ready_out) else $error("ready high during clear");
   a_chk_ready: assert property (@(posedge core_clk) disable iff (!resetn) // R20
      (q.st == PM_STEST) |=> (!ready_out ##1 !ready_out)) else $error("ready high during check");
   a_clr_zero: assert property (@(posedge core_clk) disable iff (!resetn) // R15
      (q.st == PM_CLR && q.clr_idx == 5'h0F) |=> (q.parts == '0 && q.rejects == '0))
      else $error("counters not cleared");
   a_buzz_hold: assert property (@(posedge core_clk) disable iff (!resetn) // R14
      (q.buzz_on && q.st == PM_IDLE && !meas_active_out && !q.s_meas[1]) |=> q.buzz_on)
      else $error("buzzer dropped before next start");

   // Hold and exclusivity checks
   a_onl_hold: assert property (@(posedge core_clk) disable iff (!resetn) // R2
      online_reject_flag |=> (online_reject_flag || $rose(meas_active_out)))
      else $error("online flag dropped outside a start");
   a_lock_in_ack: assert property (@(posedge core_clk) disable iff (!resetn) // R11
      interlock_out |-> (q.st == PM_ACK)) else $error("lock high outside acknowledge");
   a_buzz_quiet: assert property (@(posedge core_clk) disable iff (!resetn) // R12
      !q.buzz_on |-> !buzzer_out) else $error("buzzer sounding while off");
   a_meas_no_ready: assert property (@(posedge core_clk) disable iff (!resetn) // R22
      meas_active_out |-> !ready_out) else $error("ready high during measurement");
   a_pass_hold: assert property (@(posedge core_clk) disable iff (!resetn) // R19
      (q.st != PM_STEST) |=> $stable(sensor_check_pass_out))
      else $error("check result changed outside a check");
endmodule

/* rtl/pmpio_pkg.sv */
// Package of constants and types for the press monitor controller handshake block
// What this block does
// R1: Online window violation during measurement raises the online reject flag.
// R2: Online reject flag clears when the next measurement begins.
// R3: Controller starts a measurement only while ready is high.
// R4: Permitted window crossing keeps flag low; forbidden exit sets it.
// R5: Six threshold switch outputs, active above set value, in measurement and test.
// R6: Absolute X switch follows reading above or below set value.
// R7: Absolute X comparison uses the sensor zero point as reference.
// R8: Absolute X switches update in standby and during measurement.
// R9: Trigger-referenced X switches change only after trigger, position relative to trigger.
// R10: Y switches follow Y reading above set value, in standby and measurement.
// R11: Acknowledged reject sets fail output, flashing lamp, interlock and buzzer PWM.
// R12: Reject confirm makes lamp steady and clears interlock and buzzer together.
// R13: After acknowledge ready returns high; lamp stays until next measurement.
// R14: Without acknowledge, buzzer stays on after reject until next measurement.
// R15: Statistics clear zeroes part, reject counters and percentage for all programs.
// R16: Controller holds statistics clear until it sees ready low.
// R17: Ready is low while statistics clear runs and high once done.
// R18: Sensor check compares X and Y against reference within tolerance.
// R19: Sensor check pass output is one on pass, zero on fail.
// R20: Ready low during sensor check; high when done with pass output valid.
// R21: Controller holds sensor check request until it sees ready low.
// R22: Controller ends measurement by dropping request; device evaluates then raises ready.
package pmpio_pkg;
   localparam int           N_SW          = 6;
   localparam int           DW            = 16;
   localparam int           N_PROG        = 16;
   localparam int           CW            = 16;
   localparam int           CLK_MHZ       = 20;
   localparam int           FLASH_MS      = 250;
   localparam int           FLASH_CYC     = FLASH_MS * CLK_MHZ * 1000;
   localparam logic [7:0]   PWM_PERIOD    = 8'hC7;
   localparam logic [7:0]   PWM_HIGH      = 8'h64;
   localparam logic [1:0]   REF_ABS       = 2'h0;
   localparam logic [1:0]   REF_TRIG      = 2'h1;
   localparam logic [1:0]   CH_X          = 2'h0;
   localparam logic [1:0]   CH_Y          = 2'h1;
   // Main sequencer, Gray along idle-measure-eval-ack path
   typedef enum logic [2:0] {
      PM_IDLE  = 3'h0,
      PM_MEAS  = 3'h1,
      PM_EVAL  = 3'h3,
      PM_ACK   = 3'h2,
      PM_CLR   = 3'h6,
      PM_STEST = 3'h7,
      PM_WAIT  = 3'h5
   } pmpio_st_t;
endpackage

/* bench/pmpio_plc_model.sv */
// Controller model driving the request pins in handshake order
`timescale 1ns/1ps
module pmpio_plc_model (
   input  wire logic core_clk,
   input  wire logic ready_out,
   output logic      meas_req_in,
   output logic      stats_clear_in,
   output logic      sensor_check_in
);
   // Requests idle low from time zero
   initial begin
      meas_req_in = 1'h0;
      stats_clear_in = 1'h0;
      sensor_check_in = 1'h0;
   end
   // Bounded wait for a ready level, always leaving on a falling edge
   task automatic wait_rdy(input logic lvl);
      @(negedge core_clk);
      for (int n = 0; n < 400 && ready_out !== lvl; n++) @(negedge core_clk);
   endtask
   // start only once standby is seen
   task automatic start_meas();
      wait_rdy(1'h1);
      meas_req_in = 1'h1;
   endtask
   // end of measurement is the request dropping
   task automatic stop_meas();
      @(negedge core_clk);
      meas_req_in = 1'h0;
   endtask
   // hold the request until ready falls, then withdraw
   task automatic pulse_req(input logic clr);
      wait_rdy(1'h1);
      if (clr) stats_clear_in = 1'h1;
      else sensor_check_in = 1'h1;
      wait_rdy(1'h0);
      stats_clear_in = 1'h0;
      sensor_check_in = 1'h0;
   endtask
endmodule

/* bench/testbench.sv */
// Self-checking bench for the controller handshake block
`timescale 1ns/1ps
module testbench;
   import pmpio_pkg::*;
   localparam int LIMIT = 20000;
   logic               core_clk, resetn, online_eval_en, ack_reject_en, test_mode;
   logic [N_SW*2-1:0]  sw_channel, sw_ref;
   logic [N_SW*DW-1:0] sw_setval;
   logic [DW-1:0]      x_zero, x_ref, y_ref, tolerance, x_val, y_val;
   logic [3:0]         prog_sel;
   logic               trigger_evt, win_bad_exit, eval_done, eval_reject, reject_confirm_in;
   logic               meas_req_in, stats_clear_in, sensor_check_in, ready_out, meas_active_out;
   logic               online_reject_flag, fail_result_out, reject_lamp_out, interlock_out;
   logic               buzzer_out, sensor_check_pass_out;
   logic [N_SW-1:0]    threshold_switch_out;
   logic [CW-1:0]      part_count_out, reject_count_out;
   logic [7:0]         reject_pct_out;
   int                 errors = 0, cmp_count = 0, cycles = 0;

   // Short flash period keeps the lamp observable in a few cycles
   pmpio_top #(.FLASH_CYCLES(4)) pmpio_top_i (.core_clk, .resetn, .meas_req_in, .reject_confirm_in,
      .stats_clear_in, .sensor_check_in, .online_eval_en, .ack_reject_en, .test_mode, .sw_channel,
      .sw_ref, .sw_setval, .x_zero, .x_ref, .y_ref, .tolerance, .prog_sel, .x_val, .y_val,
      .trigger_evt, .win_bad_exit, .eval_done, .eval_reject, .ready_out, .meas_active_out,
      .online_reject_flag, .threshold_switch_out, .fail_result_out, .reject_lamp_out,
      .interlock_out, .buzzer_out, .sensor_check_pass_out, .part_count_out, .reject_count_out,
      .reject_pct_out);
   pmpio_plc_model plc_i (.core_clk, .ready_out, .meas_req_in, .stats_clear_in, .sensor_check_in);

   // 50 ns clock
   initial begin
      core_clk = 1'h0;
      forever #25 core_clk = ~core_clk;
   end
   // Hang guard
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == LIMIT) begin
         errors++;
         summarize();
      end
   end
   task automatic summarize();
      $display("compares %0d errors %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         errors++;
         $display("Error %s expected %0h seen %0h", nm, exp, seen);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge core_clk);
   endtask
   task automatic wait_ready();
      for (int n = 0; n < 300 && ready_out !== 1'h1; n++) cyc(1);
   endtask
   // Stop, then hand the evaluation result over as a one-cycle pulse
   task automatic finish_meas(input logic rej);
      plc_i.stop_meas();
      cyc(3);
      eval_reject = rej;
      eval_done = 1'h1;
      cyc(1);
      eval_done = 1'h0;
   endtask
   // Buzzer high cycles over a little more than one PWM period
   task automatic buzz_cnt(output int b);
      b = 0;
      repeat (210) begin
         cyc(1);
         b += int'(buzzer_out === 1'h1);
      end
   endtask
   task automatic t_online();
      online_eval_en = 1'h1;
      plc_i.start_meas();
      cyc(4);
      chk("ready_meas", ready_out, 32'h0);
      chk("meas_act", meas_active_out, 32'h1);
      chk("flag_clean", online_reject_flag, 32'h0);
      win_bad_exit = 1'h1;
      cyc(2);
      win_bad_exit = 1'h0;
      chk("flag_bad", online_reject_flag, 32'h1);
      finish_meas(1'h0);
      chk("fail_ok", fail_result_out, 32'h0);
      wait_ready();
      chk("ready_end", ready_out, 32'h1);
      chk("flag_hold", online_reject_flag, 32'h1);
      plc_i.start_meas();
      cyc(4);
      chk("flag_new", online_reject_flag, 32'h0);
      finish_meas(1'h0);
      wait_ready();
      $display("test online done");
   endtask
   task automatic t_switch();
      x_val = 16'h6F;
      y_val = 16'hC9;
      cyc(3);
      chk("sw_above", threshold_switch_out, 32'h3);
      x_val = 16'h69;
      y_val = 16'hC7;
      cyc(3);
      chk("sw_below", threshold_switch_out, 32'h0);
      x_val = 16'h5;
      cyc(3);
      chk("sw_under_zero", threshold_switch_out, 32'h0);
      plc_i.start_meas();
      x_val = 16'h64;
      cyc(4);
      trigger_evt = 1'h1;
      cyc(1);
      trigger_evt = 1'h0;
      x_val = 16'hA0;
      y_val = 16'hC9;
      cyc(3);
      chk("sw_trig_on", threshold_switch_out, 32'h7);
      x_val = 16'h8C;
      cyc(3);
      chk("sw_trig_off", threshold_switch_out, 32'h3);
      x_val = 16'h50;
      cyc(3);
      chk("sw_behind_trig", threshold_switch_out, 32'h2);
      finish_meas(1'h0);
      wait_ready();
      $display("test switch done");
   endtask
   task automatic t_ack();
      int t;
      int b;
      logic l;
      ack_reject_en = 1'h1;
      plc_i.start_meas();
      cyc(4);
      finish_meas(1'h1);
      cyc(1);
      chk("fail_rej", fail_result_out, 32'h1);
      chk("lock_on", interlock_out, 32'h1);
      chk("ready_ack", ready_out, 32'h0);
      t = 0;
      l = reject_lamp_out;
      repeat (12) begin
         cyc(1);
         t += int'(reject_lamp_out !== l);
         l = reject_lamp_out;
      end
      chk("lamp_flash", t >= 2, 32'h1);
      buzz_cnt(b);
      chk("buzz_pwm", b > 0 && b < 210, 32'h1);
      reject_confirm_in = 1'h1;
      cyc(5);
      reject_confirm_in = 1'h0;
      chk("lamp_steady", reject_lamp_out, 32'h1);
      chk("lock_off", interlock_out, 32'h0);
      chk("buzz_off", buzzer_out, 32'h0);
      wait_ready();
      cyc(20);
      chk("ready_back", ready_out, 32'h1);
      chk("lamp_keep", reject_lamp_out, 32'h1);
      plc_i.start_meas();
      cyc(4);
      chk("lamp_clear", reject_lamp_out, 32'h0);
      finish_meas(1'h0);
      wait_ready();
      ack_reject_en = 1'h0;
      $display("test ack done");
   endtask
   task automatic t_noack();
      int b;
      prog_sel = 4'h1;
      plc_i.start_meas();
      cyc(4);
      finish_meas(1'h1);
      wait_ready();
      buzz_cnt(b);
      chk("buzz_stay", b > 0, 32'h1);
      plc_i.start_meas();
      cyc(4);
      chk("buzz_stop", buzzer_out, 32'h0);
      finish_meas(1'h0);
      wait_ready();
      chk("parts_pre", part_count_out, 32'h2);
      chk("rej_pre", reject_count_out, 32'h1);
      cyc(1);
      chk("pct_pre", reject_pct_out, 32'h32);
      $display("test noack done");
   endtask
   task automatic t_clear();
      plc_i.pulse_req(1'h1);
      chk("ready_clr", ready_out, 32'h0);
      wait_ready();
      chk("ready_clr_end", ready_out, 32'h1);
      chk("parts1", part_count_out, 32'h0);
      chk("rej1", reject_count_out, 32'h0);
      chk("pct1", reject_pct_out, 32'h0);
      prog_sel = 4'h0;
      cyc(2);
      chk("parts0", part_count_out, 32'h0);
      $display("test clear done");
   endtask
   task automatic t_sensor(input logic [DW-1:0] dx, input logic exp);
      x_val = x_ref + dx;
      y_val = y_ref + 16'h2;
      plc_i.pulse_req(1'h0);
      chk("ready_chk", ready_out, 32'h0);
      wait_ready();
      chk("stest_pass", sensor_check_pass_out, {31'h0, exp});
      $display("test sensor done");
   endtask
   // Time-zero inputs, reset, then the scenarios in turn
   initial begin
      resetn = 1'h0;
      {online_eval_en, ack_reject_en, test_mode, trigger_evt} = 4'h0;
      {win_bad_exit, eval_done, eval_reject, reject_confirm_in} = 4'h0;
      sw_channel = 12'h544;
      sw_ref = 12'h010;
      sw_setval = {16'hFFFF, 16'hFFFF, 16'hFFFF, 16'h0032, 16'h00C8, 16'h0064};
      x_zero = 16'h000A;
      x_ref = 16'h03E8;
      y_ref = 16'h07D0;
      tolerance = 16'h0005;
      prog_sel = 4'h0;
      x_val = 16'h0;
      y_val = 16'h0;
      cyc(4);
      resetn = 1'h1;
      cyc(2);
      t_online();
      t_switch();
      t_ack();
      t_noack();
      t_clear();
      t_sensor(16'h3, 1'h1);
      t_sensor(16'h9, 1'h0);
      summarize();
   end
endmodule
